/* File: logic/tpwm_top.sv */
// Purpose: 8-bit timer pwm output channel with axi4-lite registers
// Assumes: single clock CLK at 10 MHz, NRST async active low
// Notes:   count clock is an enable derived from CLK by a prescaler
`timescale 1ns/1ps
`default_nettype none
module tpwm_top (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             PULSE_OUTPUT,
  output logic             PERIOD_MATCH_IRQ
);

  typedef enum logic [1:0] {
    TPWM_CMP_PERIOD = 2'b01,
    TPWM_CMP_DUTY   = 2'b10
  } tpwm_cmp_e;

  // write channel capture
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [1:0]  bresp_q;

  logic [7:0]  mode_q;
  logic [7:0]  period_q;
  logic [7:0]  stage_q;
  logic [7:0]  duty_q;
  logic        stage_pend_q;
  logic [1:0]  stage_age_q;
  logic        duty_armed_q;
  logic [7:0]  cnt_q;
  logic        masked_q;
  tpwm_cmp_e   sel_q;
  logic        out_act_q;
  logic        irq_q;
  logic [11:0] pre_q;
  logic        ps_tick_q;

  wire do_write  = aw_have_q && w_have_q && !bvalid_q;
  wire wr_mode   = do_write && awaddr_q == tpwm_pkg::OFF_MODE;
  wire wr_period = do_write && awaddr_q == tpwm_pkg::OFF_PERIOD;
  wire wr_duty   = do_write && awaddr_q == tpwm_pkg::OFF_DUTY;
  wire wr_ok     = wr_mode || wr_period || wr_duty;

  wire       run      = mode_q[tpwm_pkg::MODE_RUN_BIT];
  wire       idle_lev = mode_q[tpwm_pkg::MODE_LEV_BIT];
  wire       oen      = mode_q[tpwm_pkg::MODE_OEN_BIT];
  wire [2:0] cks      = mode_q[tpwm_pkg::MODE_CKS_LSB +: 3];
  wire [1:0] md       = mode_q[tpwm_pkg::MODE_MD_LSB +: 2];
  wire       pwm_mode = md == tpwm_pkg::MD_PWM;

  function automatic logic [3:0] cks_shift(input logic [2:0] sel);
    unique case (sel)
      3'h0:    cks_shift = tpwm_pkg::SHIFT_0;
      3'h1:    cks_shift = tpwm_pkg::SHIFT_1;
      3'h2:    cks_shift = tpwm_pkg::SHIFT_2;
      3'h3:    cks_shift = tpwm_pkg::SHIFT_3;
      3'h4:    cks_shift = tpwm_pkg::SHIFT_4;
      default: cks_shift = tpwm_pkg::SHIFT_5;
    endcase
  endfunction

  // count clock enable: one CLK pulse every 2^shift cycles
  wire [11:0] pre_mask = 12'((13'h1 << cks_shift(cks)) - 13'h1);
  wire        tick_d   = run && ((pre_q & pre_mask) == pre_mask);
  wire        tick     = ps_tick_q;

  // comparison target and matches
  wire [7:0] cmp_val     = (sel_q == TPWM_CMP_PERIOD) ? period_q : duty_q;
  wire       match_cmp   = tick && !masked_q && cnt_q == cmp_val;
  wire       period_hit  = match_cmp && (sel_q == TPWM_CMP_PERIOD || !pwm_mode);
  wire       duty_hit    = match_cmp && sel_q == TPWM_CMP_DUTY && pwm_mode;
  // staged duty moves only once aged three count clocks
  wire       xfer        = duty_hit && stage_pend_q && stage_age_q == tpwm_pkg::XFER_MIN_CNT;

  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_have_q && !bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  // output drive: idle level when stopped or inactive
  wire pulse_d = oen ? (idle_lev ^ out_act_q) : idle_lev;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_q <= 1'b1;
      wdata_q  <= S_AXI_WDATA & {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}}, {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bvalid_q <= 1'b0;
      bresp_q  <= tpwm_pkg::AXI_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? tpwm_pkg::AXI_OKAY : tpwm_pkg::AXI_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // read mux; status shows live block state
  wire [31:0] rd_mux =
    (S_AXI_ARADDR == tpwm_pkg::OFF_MODE)   ? {24'h0, mode_q} :
    (S_AXI_ARADDR == tpwm_pkg::OFF_PERIOD) ? {24'h0, period_q} :
    (S_AXI_ARADDR == tpwm_pkg::OFF_DUTY)   ? {24'h0, stage_q} :
    (S_AXI_ARADDR == tpwm_pkg::OFF_STATUS) ? {28'h0, stage_pend_q, irq_q, out_act_q, sel_q == TPWM_CMP_DUTY} :
    (S_AXI_ARADDR == tpwm_pkg::OFF_COUNT)  ? {24'h0, cnt_q} : 32'h0;
  wire rd_ok = S_AXI_ARADDR == tpwm_pkg::OFF_MODE || S_AXI_ARADDR == tpwm_pkg::OFF_PERIOD
            || S_AXI_ARADDR == tpwm_pkg::OFF_DUTY || S_AXI_ARADDR == tpwm_pkg::OFF_STATUS
            || S_AXI_ARADDR == tpwm_pkg::OFF_COUNT;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= tpwm_pkg::AXI_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_ok ? tpwm_pkg::AXI_OKAY : tpwm_pkg::AXI_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // mode and period only change when stopped; run bit always writable
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_q   <= tpwm_pkg::RST_MODE;
      period_q <= tpwm_pkg::RST_PERIOD;
    end else begin
      if (wr_mode) begin
        mode_q <= run ? {wdata_q[7], mode_q[6:0]} : wdata_q[7:0];
      end
      if (wr_period && !run) begin
        period_q <= wdata_q[7:0];
      end
    end
  end

  // duty staging: write latched at any phase, aged in count clocks
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      stage_q      <= tpwm_pkg::RST_DUTY;
      stage_pend_q <= 1'b0;
      stage_age_q  <= 2'h0;
    end else if (wr_duty) begin
      stage_q      <= wdata_q[7:0];
      stage_pend_q <= 1'b1;
      stage_age_q  <= 2'h0;
    end else begin
      if (xfer || !run) begin
        stage_pend_q <= 1'b0;
      end
      if (tick && stage_age_q != tpwm_pkg::XFER_MIN_CNT) begin
        stage_age_q <= stage_age_q + 2'h1;
      end
    end
  end

  // active duty: loaded at start, then only on old-value match
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      duty_q       <= tpwm_pkg::RST_DUTY;
      duty_armed_q <= 1'b0;
    end else if (!run) begin
      duty_armed_q <= 1'b0;
    end else if (!duty_armed_q) begin
      duty_q       <= stage_q;
      duty_armed_q <= 1'b1;
    end else if (xfer) begin
      duty_q <= stage_q;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pre_q     <= 12'h0;
      ps_tick_q <= 1'b0;
    end else begin
      pre_q     <= run ? pre_q + 12'h1 : 12'h0;
      ps_tick_q <= tick_d;
    end
  end

  // counter and compare sequencing
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_q     <= 8'h00;
      masked_q  <= 1'b1;
      sel_q     <= TPWM_CMP_PERIOD;
      out_act_q <= 1'b0;
      irq_q     <= 1'b0;
    end else if (!run) begin
      cnt_q     <= 8'h00;
      masked_q  <= 1'b1;
      sel_q     <= TPWM_CMP_PERIOD;
      out_act_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      irq_q <= period_hit;
      if (tick && masked_q) begin
        masked_q <= 1'b0;
      end else if (period_hit) begin
        cnt_q <= 8'h00;
        if (pwm_mode) begin
          sel_q     <= TPWM_CMP_DUTY;
          out_act_q <= 1'b1;
        end else begin
          out_act_q <= !out_act_q;
        end
      end else if (duty_hit) begin
        cnt_q     <= cnt_q + 8'h01;
        sel_q     <= TPWM_CMP_PERIOD;
        out_act_q <= 1'b0;
      end else if (tick) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PULSE_OUTPUT <= 1'b0;
    end else begin
      PULSE_OUTPUT <= pulse_d;
    end
  end

  assign PERIOD_MATCH_IRQ = irq_q;

  chk_stop_quiet : assert property (@(posedge CLK) disable iff (!NRST)
    !run |=> !irq_q && !out_act_q)
    else $error("stopped timer left irq or output active");

  chk_irq_clears : assert property (@(posedge CLK) disable iff (!NRST)
    period_hit && run |=> irq_q && cnt_q == 8'h00)
    else $error("period match did not clear counter and pulse irq");

  chk_duty_noirq : assert property (@(posedge CLK) disable iff (!NRST)
    duty_hit && run |=> !irq_q && !out_act_q && sel_q == TPWM_CMP_PERIOD)
    else $error("duty match misbehaved");

  chk_mask_first : assert property (@(posedge CLK) disable iff (!NRST)
    $rose(run) |-> !out_act_q ##1 cnt_q == 8'h00)
    else $error("output active or count moved at start");

  chk_stop_zero : assert property (@(posedge CLK) disable iff (!NRST)
    !run && $past(!run) |-> cnt_q == 8'h00)
    else $error("counter not held at zero while stopped");

  chk_xfer_aged : assert property (@(posedge CLK) disable iff (!NRST)
    duty_hit && run && stage_pend_q && stage_age_q != tpwm_pkg::XFER_MIN_CNT |=> duty_q == $past(duty_q))
    else $error("duty transferred too early");

  chk_duty_move : assert property (@(posedge CLK) disable iff (!NRST)
    xfer && run |=> duty_q == $past(stage_q))
    else $error("staged duty not transferred on match");

  chk_polarity : assert property (@(posedge CLK) disable iff (!NRST)
    !run && $past(!run) |=> PULSE_OUTPUT == $past(idle_lev))
    else $error("idle level wrong");

  chk_count_step : assert property (@(posedge CLK) disable iff (!NRST)
    run && tick && !masked_q && !match_cmp |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not step");

  chk_duty_write : assert property (@(posedge CLK) disable iff (!NRST)
    wr_duty && run && !tick |=> cnt_q == $past(cnt_q))
    else $error("duty write disturbed counter");

endmodule
`default_nettype wire

/* File: inc/tpwm_pkg.sv */
// Purpose: shared constants for the timer pwm output block
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes:   offsets chosen for this block; count clock derived from CLK prescaler
`default_nettype none
package tpwm_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_DUTY   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_COUNT  = 8'h10;
  // mode register fields
  localparam int MODE_RUN_BIT  = 7;
  localparam int MODE_CKS_LSB  = 4;
  localparam int MODE_MD_LSB   = 2;
  localparam int MODE_LEV_BIT  = 1;
  localparam int MODE_OEN_BIT  = 0;
  localparam logic [1:0] MD_INTERVAL = 2'h0;
  localparam logic [1:0] MD_PWM      = 2'h2;
  // reset values
  localparam logic [7:0] RST_MODE   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [7:0] RST_DUTY   = 8'h00;
  // count clock divide shifts by clock select code
  localparam logic [3:0] SHIFT_0 = 4'h0;
  localparam logic [3:0] SHIFT_1 = 4'h2;
  localparam logic [3:0] SHIFT_2 = 4'h4;
  localparam logic [3:0] SHIFT_3 = 4'h6;
  localparam logic [3:0] SHIFT_4 = 4'hc;
  localparam logic [3:0] SHIFT_5 = 4'h7;
  // least count clocks between staging write and transfer
  localparam logic [1:0] XFER_MIN_CNT = 2'h3;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: bench/tpwm_load.sv */
// Purpose: load on the pwm pin, measures cycle and active widths
// Assumes: idle level supplied by the bench, widths counted in CLK cycles
// Notes:   first width after a start or stop is not meaningful
`timescale 1ns/1ps
`default_nettype none
module tpwm_load (
  input  wire logic   clk,
  input  wire logic   nrst,
  input  wire logic   pin,
  input  wire logic   idle_level,
  output logic [15:0] cycle_len,
  output logic [15:0] active_len
);
  logic [15:0] cnt_q;
  logic        act_q;
  logic        act;
  logic        rise;
  assign act  = pin ^ idle_level;
  assign rise = act && !act_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q      <= 16'h0001;
      act_q      <= 1'b0;
      cycle_len  <= 16'h0000;
      active_len <= 16'h0000;
    end else begin
      act_q <= act;
      cnt_q <= rise ? 16'h0001 : cnt_q + 16'h0001;
      if (rise) cycle_len <= cnt_q;
      if (!act && act_q) active_len <= cnt_q;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_timer_pwm_output_mode.sv */
// Purpose: self-checking bench for the pwm timer channel
// Assumes: CLK 10 MHz, registers reached over axi4-lite
// Notes:   outputs sampled at the falling edge to stay clear of launch races
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_timer_pwm_output_mode;
  typedef struct packed {
    logic [2:0]  cks;
    logic [7:0]  per;
    logic [7:0]  duty;
    logic        lev;
    logic [15:0] cyc;
    logic [15:0] act;
  } tpwm_row_s;
  logic        CLK     = 1'b0;
  logic        NRST    = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hf;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        lev     = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, PULSE_OUTPUT, PERIOD_MATCH_IRQ;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [15:0] cycle_len, active_len;
  int          fails, checks, irqs, cyc, n;
  // expected widths in CLK cycles: (value + 1) ticks, one tick per 2^shift CLK
  tpwm_row_s   rows [9] = '{
    '{3'h0, 8'h05, 8'h02, 1'b0, 16'h0006, 16'h0003},
    '{3'h0, 8'h01, 8'h00, 1'b1, 16'h0002, 16'h0001},
    '{3'h0, 8'hff, 8'h00, 1'b0, 16'h0100, 16'h0001},
    '{3'h0, 8'hff, 8'hfe, 1'b1, 16'h0100, 16'h00ff},
    '{3'h1, 8'h09, 8'h03, 1'b0, 16'h0028, 16'h0010},
    '{3'h2, 8'h03, 8'h01, 1'b1, 16'h0040, 16'h0020},
    '{3'h3, 8'h02, 8'h00, 1'b0, 16'h00c0, 16'h0040},
    '{3'h4, 8'h01, 8'h00, 1'b1, 16'h2000, 16'h1000},
    '{3'h5, 8'h01, 8'h00, 1'b0, 16'h0100, 16'h0080}};
  tpwm_top DUT (.CLK(CLK), .NRST(NRST), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .PULSE_OUTPUT(PULSE_OUTPUT), .PERIOD_MATCH_IRQ(PERIOD_MATCH_IRQ));
  tpwm_load LOAD (.clk(CLK), .nrst(NRST), .pin(PULSE_OUTPUT), .idle_level(lev), .cycle_len(cycle_len),
    .active_len(active_len));
  initial begin
    forever #50 CLK = ~CLK;
  end
  always @(negedge CLK) begin
    if (PERIOD_MATCH_IRQ === 1'b1) irqs++;
  end
  // ready sampled at the falling edge, so the taking edge is the next rising one
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    b_ok  = 1'b0;
    @(posedge CLK);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, v};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge CLK);
      aw_ok = aw_ok | (awvalid & awready);
      w_ok  = w_ok | (wvalid & wready);
      @(posedge CLK);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    while (!b_ok) begin
      @(negedge CLK);
      b_ok = (bvalid === 1'b1);
      r    = bresp;
      @(posedge CLK);
    end
    bready <= 1'b0;
    `CHK(r, er)
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok  = 1'b0;
    @(posedge CLK);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!ar_ok) begin
      @(negedge CLK);
      ar_ok = (arvalid & arready) === 1'b1;
      @(posedge CLK);
    end
    arvalid <= 1'b0;
    while (!r_ok) begin
      @(negedge CLK);
      r_ok = (rvalid === 1'b1);
      d    = rdata;
      r    = rresp;
      @(posedge CLK);
    end
    rready <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #8000000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    foreach (rows[i]) begin
      cyc = int'(rows[i].cyc);
      wr(tpwm_pkg::OFF_MODE, {6'h00, lev, 1'b0}, tpwm_pkg::AXI_OKAY);
      lev <= rows[i].lev;
      wr(tpwm_pkg::OFF_PERIOD, rows[i].per, tpwm_pkg::AXI_OKAY);
      wr(tpwm_pkg::OFF_DUTY, rows[i].duty, tpwm_pkg::AXI_OKAY);
      wr(tpwm_pkg::OFF_MODE, {1'b1, rows[i].cks, tpwm_pkg::MD_PWM, lev, 1'b1}, tpwm_pkg::AXI_OKAY);
      @(negedge CLK);
      `CHK(PULSE_OUTPUT, lev)
      repeat (4 * cyc) @(posedge CLK);
      @(negedge CLK);
      `CHK(cycle_len, rows[i].cyc)
      `CHK(active_len, rows[i].act)
      // clear on a rising edge so the negedge counter never races the clear
      @(posedge CLK);
      irqs = 0;
      repeat (2 * cyc) @(posedge CLK);
      `CHK(irqs, 2)
    end
    wr(tpwm_pkg::OFF_MODE, 8'h00, tpwm_pkg::AXI_OKAY);
    lev <= 1'b0;
    wr(tpwm_pkg::OFF_PERIOD, 8'ha5, tpwm_pkg::AXI_OKAY);
    wr(tpwm_pkg::OFF_DUTY, 8'h01, tpwm_pkg::AXI_OKAY);
    wr(tpwm_pkg::OFF_MODE, 8'h89, tpwm_pkg::AXI_OKAY);
    repeat (500) @(posedge CLK);
    wr(tpwm_pkg::OFF_DUTY, 8'h03, tpwm_pkg::AXI_OKAY);
    repeat (664) @(posedge CLK);
    @(negedge CLK);
    `CHK(cycle_len, 16'd166)
    `CHK(active_len, 16'd4)
    rd(tpwm_pkg::OFF_DUTY);
    `CHK(d, 32'h3)
    wr(tpwm_pkg::OFF_DUTY, 8'h90, tpwm_pkg::AXI_OKAY);
    repeat (400) @(posedge CLK);
    // stop just after the output goes active, so the forced return is seen
    for (n = 0; n < 400 && PULSE_OUTPUT !== 1'b0; n++) @(negedge CLK);
    for (n = 0; n < 400 && PULSE_OUTPUT !== 1'b1; n++) @(negedge CLK);
    `CHK(PULSE_OUTPUT, 1'b1)
    wr(tpwm_pkg::OFF_MODE, 8'h09, tpwm_pkg::AXI_OKAY);
    // state clears one edge after the stop, the pin one edge later
    repeat (2) @(negedge CLK);
    `CHK(PULSE_OUTPUT, 1'b0)
    irqs = 0;
    repeat (200) @(posedge CLK);
    `CHK(irqs, 0)
    rd(tpwm_pkg::OFF_COUNT);
    `CHK(d, 32'h0)
    rd(tpwm_pkg::OFF_STATUS);
    `CHK(d, 32'h0)
    wr(8'h14, 8'h55, tpwm_pkg::AXI_SLVERR);
    rd(8'h14);
    `CHK(r, tpwm_pkg::AXI_SLVERR)
    `CHK(d, 32'h0)
    // interval mode: output toggles on each period match
    wr(tpwm_pkg::OFF_PERIOD, 8'h04, tpwm_pkg::AXI_OKAY);
    wr(tpwm_pkg::OFF_MODE, 8'h81, tpwm_pkg::AXI_OKAY);
    repeat (40) @(posedge CLK);
    @(negedge CLK);
    `CHK(cycle_len, 16'h000a)
    `CHK(active_len, 16'h0005)
    wr(tpwm_pkg::OFF_MODE, 8'h01, tpwm_pkg::AXI_OKAY);
    wr(tpwm_pkg::OFF_DUTY, 8'h01, tpwm_pkg::AXI_OKAY);
    wr(tpwm_pkg::OFF_MODE, 8'h89, tpwm_pkg::AXI_OKAY);
    repeat (250) @(posedge CLK);
    NRST <= 1'b0;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    `CHK(PULSE_OUTPUT, 1'b0)
    `CHK(PERIOD_MATCH_IRQ, 1'b0)
    @(posedge CLK);
    NRST <= 1'b1;
    rd(tpwm_pkg::OFF_MODE);
    `CHK(d, {24'h0, tpwm_pkg::RST_MODE})
    rd(tpwm_pkg::OFF_PERIOD);
    `CHK(d, {24'h0, tpwm_pkg::RST_PERIOD})
    rd(tpwm_pkg::OFF_DUTY);
    `CHK(d, {24'h0, tpwm_pkg::RST_DUTY})
    print_verdict();
  end
endmodule
`default_nettype wire
